// ==== inc/smc_pkg.sv ====
package smc_pkg;
    // ==================================================
    // Register map (byte addresses)
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_IRQ_DIV = 12'h414;
    localparam logic [11:0] OFS_RAM_ILV = 12'h470;
    localparam logic [11:0] OFS_CPU_STAT = 12'h80C;
    localparam logic [11:0] OFS_CACHE = 12'h824;
    localparam logic [11:0] OFS_PWM_A = 12'h938;
    localparam logic [11:0] OFS_PWM_B = 12'h93C;
    localparam logic [11:0] OFS_TMR = 12'h940;
    localparam logic [11:0] OFS_RAM_CTRL = 12'h944;
    localparam logic [11:0] OFS_GRAY_LO = 12'hB60;
    localparam logic [11:0] OFS_GRAY_HI = 12'hB64;
    localparam logic [11:0] OFS_BIN_LO = 12'hB68;
    localparam logic [11:0] OFS_BIN_HI = 12'hB6C;
    // ==================================================
    // Field widths and positions
    localparam int IRQ_W = 22;
    localparam int PWM_W = 4;
    localparam int TMR_W = 5;
    localparam int BANK_N = 4;
    localparam int GRAY_W = 42;
    localparam int GRAY_HI_W = 10;
    localparam int STAT_SLEEP = 0;
    localparam int STAT_LOCK = 2;
    localparam int CC_DIS = 0;
    localparam int CC_CLR = 1;
    localparam int CC_NOALLOC = 2;
    localparam int CC_WDIS = 4;
    localparam int CC_WLIM = 5;
    localparam int CC_SPLIT = 7;
    localparam int CC_CLAIM = 8;
    localparam int RC_ECC = 0;
    localparam int RC_OVR = 16;
    localparam int BANK_A = 0;
    // ==================================================
    // Reset values and timing
    localparam logic RST_ECC = 1'b1;
    localparam logic [4:0] IDLE_LIMIT = 5'h10;
    localparam logic [4:0] IDLE_SAT = 5'h11;
endpackage

// ==== verilog/smc_bank.sv ====
// Function
// (R01) A 22-bit vector diverts each enabled interrupt to the DMA engine.
// (R02) Vector bits map upward to interrupts 2,23,26..45 as listed.
// (R03) Software writes zeros to bits 31:22 and ignores their read value.
// (R04) Interleave bit selects consecutive or interleaved banks A1/A2.
// (R05) Status register shows core lockup in bit 2, sleep in bit 0.
// (R06) Cache RAM claim bit, once written 1, stays 1 until reset.
// (R07) Fetch-attribute split bit keeps instructions and data apart.
// (R08) Software sets split bit only with execute-only regions configured.
// (R09) Buffer limit bit restricts buffering to cacheable-bufferable writes.
// (R10) Buffer disable bit turns the write-through buffer off.
// (R11) No-allocate bit stops the cache allocating new lines.
// (R12) Clear bit flushes cache contents; disable bit turns cache off.
// (R13) Two registers gate the four submodule clocks of each PWM.
// (R14) Five bits enable counter/timer function clocks, reset to zero.
// (R15) Per-bank override bits disable auto gating after 16 idle cycles.
// (R16) Bank A auto gating works only while its ECC is off.
// (R17) Each bank idles out; first read after stop costs one cycle.
// (R18) Bank A ECC enable bit resets to one.
// (R19) Converter takes 42-bit Gray code from two zero-reset registers.
// (R20) Upper Gray bits 41:32 sit in bits 9:0, rest reserved.
// (R21) Binary result reads at two offsets, high part in bits 9:0.
// (R22) Binary bit i is XOR of Gray bits 41 down to i.
// (R23) Reserved bits ignore writes and read as zero.
module smc_bank (
    input wire logic clk, // 250 MHz
    input wire logic sys_rst, // Sync reset, high
    input wire logic [smc_pkg::ADDR_W-1:0] addr, // Byte address
    input wire logic [31:0] wdata, // Write data
    input wire logic wr, // Write strobe
    input wire logic rd, // Read strobe
    output logic [31:0] rdata, // Read data, cycle after rd
    input wire logic [smc_pkg::IRQ_W-1:0] irq_src, // Interrupt pins
    output logic [smc_pkg::IRQ_W-1:0] irq_to_cpu, // Undiverted
    output logic [smc_pkg::IRQ_W-1:0] irq_to_dma, // Diverted
    input wire logic core_lockup_flag, // Core lockup pin
    input wire logic core_sleep_flag, // Core sleep pin
    output logic ram_interleave, // Banks A1/A2 interleaved
    output logic cache_ram_claim, // Shared RAM X1 given to cache
    output logic cache_fetch_attr_split, // Fetch attr in lookup
    output logic wt_buffer_limit, // Buffer only cacheable ones
    output logic wt_buffer_disable, // Buffer off
    output logic force_no_allocate, // No line allocation
    output logic cache_clear, // One-cycle flush pulse
    output logic cache_disable, // Cache off
    output logic [smc_pkg::PWM_W-1:0] pwm_a_clk_on, // PWM A clocks
    output logic [smc_pkg::PWM_W-1:0] pwm_b_clk_on, // PWM B clocks
    output logic [smc_pkg::TMR_W-1:0] timer_clock_on, // Timer clocks
    output logic bank_a_ecc_on, // Bank A ECC enable
    input wire logic [smc_pkg::BANK_N-1:0] bank_rd, // Bank reads A,X,B,C
    input wire logic [smc_pkg::BANK_N-1:0] bank_wr, // Bank writes
    output logic [smc_pkg::BANK_N-1:0] bank_clk_on, // Bank clock runs
    output logic [smc_pkg::BANK_N-1:0] bank_read_stall // Extra cycle
);
    import smc_pkg::*;

    // ==================================================
    // State
    typedef struct packed {
        logic [IRQ_W-1:0] div;
        logic ilv;
        logic claim;
        logic split;
        logic wlim;
        logic wdis;
        logic noalloc;
        logic clr;
        logic cdis;
        logic [PWM_W-1:0] pwma;
        logic [PWM_W-1:0] pwmb;
        logic [TMR_W-1:0] tmr;
        logic [BANK_N-1:0] ovr;
        logic ecc;
        logic [31:0] glo;
        logic [GRAY_HI_W-1:0] ghi;
        logic [31:0] rdata;
        logic lk_s1;
        logic lk_s2;
        logic sl_s1;
        logic sl_s2;
        logic [IRQ_W-1:0] irq_s1;
        logic [IRQ_W-1:0] irq_s2;
        logic [IRQ_W-1:0] to_cpu;
        logic [IRQ_W-1:0] to_dma;
        logic [BANK_N-1:0][4:0] idle;
        logic [BANK_N-1:0] clk_on;
        logic [BANK_N-1:0] stall;
    } smc_state_t;

    smc_state_t st_q;
    smc_state_t st_d;

    // ==================================================
    // Gray to binary convert
    // The result is plain logic on the stored inputs, so a read always sees
    // the registers written on earlier cycles and no start is needed.
    logic [GRAY_W-1:0] gray_in;
    wire [GRAY_W-1:0] bin_out;

    assign gray_in = {st_q.ghi, st_q.glo}; // R19 R20

    for (genvar i = 0; i < GRAY_W; i++) begin : g_gray
        // Each binary bit folds in every Gray bit at and above it.
        assign bin_out[i] = ^gray_in[GRAY_W-1:i]; // R22
    end

    // ==================================================
    // Bank idle timers and clock gating
    wire [BANK_N-1:0][4:0] bank_idle_nx;
    wire [BANK_N-1:0] bank_on_nx;
    wire [BANK_N-1:0] bank_stall_nx;

    for (genvar b = 0; b < BANK_N; b++) begin : g_bank
        wire acc;
        wire auto_ok;
        assign acc = bank_rd[b] | bank_wr[b];
        if (b == BANK_A) begin : g_ecc
            // ECC on bank A keeps its clock running whatever the override.
            assign auto_ok = ~st_q.ovr[b] & ~st_q.ecc; // R15 R16
        end else begin : g_plain
            assign auto_ok = ~st_q.ovr[b]; // R15
        end
        // The count saturates one past the limit so it never wraps back on.
        assign bank_idle_nx[b] = acc ? 5'h00
            : (st_q.idle[b] == IDLE_SAT) ? IDLE_SAT
            : st_q.idle[b] + 5'h01; // R17
        // Gated once more than 16 idle cycles have passed.
        assign bank_on_nx[b] =
            ~(auto_ok & (bank_idle_nx[b] > IDLE_LIMIT)); // R15
        // Only a read waits for the wake; a write is free.
        assign bank_stall_nx[b] = bank_rd[b] & ~st_q.clk_on[b]; // R17
    end

    // ==================================================
    // Next state
    always_comb begin
        st_d = st_q;

        // Pins cross into this clock through two stages.
        st_d.lk_s1 = core_lockup_flag;
        st_d.lk_s2 = st_q.lk_s1;
        st_d.sl_s1 = core_sleep_flag;
        st_d.sl_s2 = st_q.sl_s1;
        st_d.irq_s1 = irq_src;
        st_d.irq_s2 = st_q.irq_s1;

        st_d.to_dma = st_q.irq_s2 & st_q.div; // R01 R02
        st_d.to_cpu = st_q.irq_s2 & ~st_q.div; // R01

        // The flush is a pulse; the stored bit never holds it.
        st_d.clr = 1'b0;

        if (wr) begin
            unique case (addr)
                OFS_IRQ_DIV: st_d.div = wdata[IRQ_W-1:0]; // R01 R03
                OFS_RAM_ILV: st_d.ilv = wdata[0]; // R04
                OFS_CACHE: begin
                    // Once claimed, the RAM cannot be handed back.
                    st_d.claim = st_q.claim | wdata[CC_CLAIM]; // R06
                    st_d.split = wdata[CC_SPLIT]; // R07
                    st_d.wlim = wdata[CC_WLIM]; // R09
                    st_d.wdis = wdata[CC_WDIS]; // R10
                    st_d.noalloc = wdata[CC_NOALLOC]; // R11
                    st_d.clr = wdata[CC_CLR]; // R12
                    st_d.cdis = wdata[CC_DIS]; // R12
                end
                OFS_PWM_A: st_d.pwma = wdata[PWM_W-1:0]; // R13
                OFS_PWM_B: st_d.pwmb = wdata[PWM_W-1:0]; // R13
                OFS_TMR: st_d.tmr = wdata[TMR_W-1:0]; // R14
                OFS_RAM_CTRL: begin
                    st_d.ovr = wdata[RC_OVR+:BANK_N]; // R15
                    st_d.ecc = wdata[RC_ECC]; // R18
                end
                OFS_GRAY_LO: st_d.glo = wdata; // R19
                OFS_GRAY_HI: st_d.ghi = wdata[GRAY_HI_W-1:0]; // R20
                default: begin
                end
            endcase
        end

        if (rd) begin
            st_d.rdata = '0; // R23
            unique case (addr)
                OFS_IRQ_DIV: st_d.rdata[IRQ_W-1:0] = st_q.div; // R03
                OFS_RAM_ILV: st_d.rdata[0] = st_q.ilv;
                OFS_CPU_STAT: begin
                    st_d.rdata[STAT_LOCK] = st_q.lk_s2; // R05
                    st_d.rdata[STAT_SLEEP] = st_q.sl_s2; // R05
                end
                OFS_CACHE: begin
                    st_d.rdata[CC_CLAIM] = st_q.claim;
                    st_d.rdata[CC_SPLIT] = st_q.split;
                    st_d.rdata[CC_WLIM] = st_q.wlim;
                    st_d.rdata[CC_WDIS] = st_q.wdis;
                    st_d.rdata[CC_NOALLOC] = st_q.noalloc;
                    st_d.rdata[CC_DIS] = st_q.cdis;
                end
                OFS_PWM_A: st_d.rdata[PWM_W-1:0] = st_q.pwma;
                OFS_PWM_B: st_d.rdata[PWM_W-1:0] = st_q.pwmb;
                OFS_TMR: st_d.rdata[TMR_W-1:0] = st_q.tmr;
                OFS_RAM_CTRL: begin
                    st_d.rdata[RC_OVR+:BANK_N] = st_q.ovr;
                    st_d.rdata[RC_ECC] = st_q.ecc;
                end
                OFS_GRAY_LO: st_d.rdata = st_q.glo; // R19
                OFS_GRAY_HI: st_d.rdata[GRAY_HI_W-1:0] = st_q.ghi; // R20
                OFS_BIN_LO: st_d.rdata = bin_out[31:0]; // R21
                OFS_BIN_HI: begin
                    st_d.rdata[GRAY_HI_W-1:0] = bin_out[GRAY_W-1:32]; // R21
                end
                default: begin
                end
            endcase
        end else begin
            // Data stand only in the cycle after the read.
            st_d.rdata = '0;
        end

        // Bank timers come from the per-bank logic above.
        st_d.idle = bank_idle_nx; // R17
        st_d.clk_on = bank_on_nx; // R15
        st_d.stall = bank_stall_nx; // R17

        if (sys_rst) begin
            st_d = '0;
            st_d.ecc = RST_ECC; // R18
            st_d.clk_on = '1;
        end
    end

    always_ff @(posedge clk) begin
        st_q <= st_d;
    end

    // ==================================================
    // Outputs
    assign rdata = st_q.rdata;
    assign irq_to_cpu = st_q.to_cpu;
    assign irq_to_dma = st_q.to_dma;
    assign ram_interleave = st_q.ilv;
    assign cache_ram_claim = st_q.claim;
    assign cache_fetch_attr_split = st_q.split;
    assign wt_buffer_limit = st_q.wlim;
    assign wt_buffer_disable = st_q.wdis;
    assign force_no_allocate = st_q.noalloc;
    assign cache_clear = st_q.clr;
    assign cache_disable = st_q.cdis;
    assign pwm_a_clk_on = st_q.pwma;
    assign pwm_b_clk_on = st_q.pwmb;
    assign timer_clock_on = st_q.tmr;
    assign bank_a_ecc_on = st_q.ecc;
    assign bank_clk_on = st_q.clk_on;
    assign bank_read_stall = st_q.stall;

    // ==================================================
    // Checks
    a_irq_route: assert property ( // R01
        @(posedge clk) disable iff (sys_rst)
        ##1 (irq_to_dma == ($past(st_q.irq_s2) & $past(st_q.div)))
    ) else $error("diverted interrupts do not follow the vector");

    a_claim_lock: assert property ( // R06
        @(posedge clk) disable iff (sys_rst)
        cache_ram_claim |=> cache_ram_claim
    ) else $error("cache RAM claim dropped without reset");

    a_clear_pulse: assert property ( // R12
        @(posedge clk) disable iff (sys_rst)
        (wr && addr == OFS_CACHE && wdata[CC_CLR]) |=> cache_clear
    ) else $error("cache flush pulse missing");

    a_gate_override: assert property ( // R15
        @(posedge clk) disable iff (sys_rst)
        st_q.ovr[1] |=> bank_clk_on[1]
    ) else $error("bank X gated while override set");

    a_ecc_blocks: assert property ( // R16
        @(posedge clk) disable iff (sys_rst)
        st_q.ecc |=> bank_clk_on[BANK_A]
    ) else $error("bank A gated while ECC on");

    a_read_stall: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        (bank_rd[BANK_A] && !bank_clk_on[BANK_A]) |=>
            bank_read_stall[BANK_A]
    ) else $error("first read after stop not stalled");

    a_write_free: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        !bank_rd[1] |=> !bank_read_stall[1]
    ) else $error("stall without a read");

    a_hi_reserved: assert property ( // R23
        @(posedge clk) disable iff (sys_rst)
        (rd && addr == OFS_GRAY_HI) |=> (rdata[31:GRAY_HI_W] == '0)
    ) else $error("reserved gray bits read nonzero");

    a_lock_flag: assert property ( // R05
        @(posedge clk) disable iff (sys_rst)
        (rd && addr == OFS_CPU_STAT) |=>
            (rdata[STAT_LOCK] == $past(st_q.lk_s2))
    ) else $error("lockup status wrong");

    a_irq_split: assert property ( // R01
        @(posedge clk) disable iff (sys_rst)
        (irq_to_cpu & irq_to_dma) == '0
    ) else $error("interrupt routed to both targets");

    a_reset_state: assert property ( // R14 R18 R19
        @(posedge clk)
        $fell(sys_rst) |-> (bank_a_ecc_on && timer_clock_on == '0
            && st_q.glo == '0 && st_q.ghi == '0)
    ) else $error("register bank not at reset values");

    a_ilv_write: assert property ( // R04
        @(posedge clk) disable iff (sys_rst)
        (wr && addr == OFS_RAM_ILV) |=> (ram_interleave == $past(wdata[0]))
    ) else $error("interleave select not written");

    a_claim_set: assert property ( // R06
        @(posedge clk) disable iff (sys_rst)
        (wr && addr == OFS_CACHE && wdata[CC_CLAIM]) |=> cache_ram_claim
    ) else $error("cache RAM claim not taken");

    a_split_write: assert property ( // R07
        @(posedge clk) disable iff (sys_rst)
        (wr && addr == OFS_CACHE) |=>
            (cache_fetch_attr_split == $past(wdata[CC_SPLIT]))
    ) else $error("fetch attribute split not written");

    a_buf_write: assert property ( // R09 R10
        @(posedge clk) disable iff (sys_rst)
        (wr && addr == OFS_CACHE) |=>
            ({wt_buffer_limit, wt_buffer_disable} ==
                $past({wdata[CC_WLIM], wdata[CC_WDIS]}))
    ) else $error("write-through buffer controls not written");

    a_alloc_write: assert property ( // R11 R12
        @(posedge clk) disable iff (sys_rst)
        (wr && addr == OFS_CACHE) |=>
            ({force_no_allocate, cache_disable} ==
                $past({wdata[CC_NOALLOC], wdata[CC_DIS]}))
    ) else $error("allocation or disable control not written");

    a_pwm_write: assert property ( // R13
        @(posedge clk) disable iff (sys_rst)
        (wr && addr == OFS_PWM_B) |=>
            (pwm_b_clk_on == $past(wdata[PWM_W-1:0]))
    ) else $error("second PWM clock enables not written");

    a_tmr_write: assert property ( // R14
        @(posedge clk) disable iff (sys_rst)
        (wr && addr == OFS_TMR) |=>
            (timer_clock_on == $past(wdata[TMR_W-1:0]))
    ) else $error("timer clock enables not written");

    a_wake_access: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        (bank_rd[BANK_A] || bank_wr[BANK_A]) |=> bank_clk_on[BANK_A]
    ) else $error("bank A not woken by an access");

    a_gate_idle: assert property ( // R15
        @(posedge clk) disable iff (sys_rst)
        $fell(bank_clk_on[BANK_A]) |-> (st_q.idle[BANK_A] > IDLE_LIMIT)
    ) else $error("bank A gated before its idle time ran out");

    a_stall_once: assert property ( // R17
        @(posedge clk) disable iff (sys_rst)
        bank_read_stall[BANK_A] |=> !bank_read_stall[BANK_A]
    ) else $error("read stall longer than one cycle");

    a_bin_reserved: assert property ( // R21
        @(posedge clk) disable iff (sys_rst)
        (rd && addr == OFS_BIN_HI) |=> (rdata[31:GRAY_HI_W] == '0)
    ) else $error("reserved binary bits read nonzero");

    a_rdata_idle: assert property ( // R23
        @(posedge clk) disable iff (sys_rst)
        !rd |=> (rdata == '0)
    ) else $error("read data stand outside the answer cycle");
endmodule

// ==== tb/tb_top.sv ====
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import smc_pkg::*;
    // ==================================================
    // Stimulus and observed signals
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [31:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [IRQ_W-1:0] irq_src = '0;
    logic [IRQ_W-1:0] irq_to_cpu, irq_to_dma;
    logic core_lockup_flag = 1'b0;
    logic core_sleep_flag = 1'b0;
    logic cc_claim, cc_split, cc_wlim, cc_wdis, cc_noalloc, cc_dis;
    logic [5:0] cc;
    assign cc = {cc_claim, cc_split, cc_wlim, cc_wdis, cc_noalloc, cc_dis};
    logic ram_interleave, cache_clear, bank_a_ecc_on;
    logic [PWM_W-1:0] pwm_a_clk_on, pwm_b_clk_on;
    logic [TMR_W-1:0] timer_clock_on;
    logic [BANK_N-1:0] bank_rd = '0;
    logic [BANK_N-1:0] bank_wr = '0;
    logic [BANK_N-1:0] bank_clk_on, bank_read_stall;
    logic [31:0] got;
    int bad_count = 0;
    int checked = 0;
    always #2 clk = ~clk;
    smc_bank uut (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .irq_src(irq_src),
        .irq_to_cpu(irq_to_cpu), .irq_to_dma(irq_to_dma),
        .core_lockup_flag(core_lockup_flag), .core_sleep_flag(core_sleep_flag),
        .ram_interleave(ram_interleave), .cache_ram_claim(cc_claim),
        .cache_fetch_attr_split(cc_split), .wt_buffer_limit(cc_wlim),
        .wt_buffer_disable(cc_wdis), .force_no_allocate(cc_noalloc),
        .cache_clear(cache_clear), .cache_disable(cc_dis),
        .pwm_a_clk_on(pwm_a_clk_on), .pwm_b_clk_on(pwm_b_clk_on),
        .timer_clock_on(timer_clock_on), .bank_a_ecc_on(bank_a_ecc_on),
        .bank_rd(bank_rd), .bank_wr(bank_wr), .bank_clk_on(bank_clk_on),
        .bank_read_stall(bank_read_stall));
    // ==================================================
    // Bus and comparison helpers
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] seen);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe, so sample there.
    task automatic rreg(input logic [11:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic wait_edges(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    function automatic logic [41:0] to_bin(input logic [41:0] g);
        logic [41:0] b;
        // Each binary bit is the parity of the Gray bits at and above it.
        for (int i = 0; i < 42; i++) b[i] = ^(g >> i);
        return b;
    endfunction
    // ==================================================
    // Scenarios
    task automatic t_reset;
        logic [11:0] ofs [10] = '{OFS_IRQ_DIV, OFS_RAM_ILV, OFS_CPU_STAT,
            OFS_CACHE, OFS_PWM_A, OFS_PWM_B, OFS_TMR, OFS_RAM_CTRL,
            OFS_GRAY_LO, OFS_GRAY_HI};
        for (int i = 0; i < 10; i++) begin
            rreg(ofs[i], got);
            chk("reset value", (ofs[i] == OFS_RAM_CTRL) ? 1 : 0, got);
        end
        chk("ecc out", 1, bank_a_ecc_on);
        chk("timer out", 0, timer_clock_on);
        $display("test reset done");
    endtask
    task automatic t_irq;
        // Bits 31:22 are written as zero and their read value is ignored.
        wreg(OFS_IRQ_DIV, 32'h003FFFFF);
        rreg(OFS_IRQ_DIV, got);
        chk("divert mask", 32'h003FFFFF, got & 32'h003FFFFF);
        wreg(OFS_IRQ_DIV, 32'h0015A5C3);
        irq_src <= 22'h3F0F0F;
        wait_edges(4);
        chk("to dma", 22'h3F0F0F & 22'h15A5C3, irq_to_dma);
        chk("to cpu", 22'h3F0F0F & ~22'h15A5C3, irq_to_cpu);
        $display("test irq done");
    endtask
    task automatic t_status;
        @(posedge clk);
        core_lockup_flag <= 1'b1;
        wait_edges(3);
        rreg(OFS_CPU_STAT, got);
        chk("lockup", 32'h4, got);
        @(posedge clk);
        core_lockup_flag <= 1'b0;
        core_sleep_flag <= 1'b1;
        wreg(OFS_CPU_STAT, 32'hFFFFFFFF);
        wait_edges(2);
        rreg(OFS_CPU_STAT, got);
        chk("sleep", 32'h1, got);
        $display("test status done");
    endtask
    task automatic t_cache;
        wreg(OFS_CACHE, 32'hFFFFFFFF);
        #1 chk("clear pulse", 1, cache_clear);
        chk("cache outs", 6'h3F, cc);
        wait_edges(1);
        chk("clear end", 0, cache_clear);
        rreg(OFS_CACHE, got);
        chk("cache read", 32'h1B5, got);
        wreg(OFS_CACHE, 32'h0);
        rreg(OFS_CACHE, got);
        chk("claim sticky", 32'h100, got);
        chk("cache outs off", 6'h20, cc);
        $display("test cache done");
    endtask
    task automatic t_clocks;
        wreg(OFS_RAM_ILV, 32'hFFFFFFFF);
        wreg(OFS_PWM_A, 32'hFFFFFFF5);
        wreg(OFS_PWM_B, 32'hFFFFFFFA);
        wreg(OFS_TMR, 32'hFFFFFFF6);
        #1 chk("outs", {1'b1, 4'h5, 4'hA, 5'h16},
            {ram_interleave, pwm_a_clk_on, pwm_b_clk_on, timer_clock_on});
        rreg(OFS_RAM_ILV, got);
        chk("interleave", 1, got);
        rreg(OFS_PWM_A, got);
        chk("pwm a", 32'h5, got);
        rreg(OFS_TMR, got);
        chk("timer", 32'h16, got);
        $display("test clocks done");
    endtask
    task automatic t_gray;
        logic [41:0] b;
        b = to_bin({10'h2B5, 32'hDEADBEEF});
        wreg(OFS_GRAY_LO, 32'hDEADBEEF);
        wreg(OFS_GRAY_HI, 32'hFFFFFEB5);
        wreg(OFS_BIN_LO, 32'h0);
        rreg(OFS_GRAY_HI, got);
        chk("gray hi", 32'h2B5, got);
        rreg(OFS_BIN_LO, got);
        chk("bin lo", b[31:0], got);
        rreg(OFS_BIN_HI, got);
        chk("bin hi", b[41:32], got);
        rreg(12'h418, got);
        chk("unmapped", 0, got);
        $display("test gray done");
    endtask
    task automatic t_banks;
        wait_edges(20);
        chk("gate ecc on", 4'h1, bank_clk_on);
        wreg(OFS_RAM_CTRL, 32'h0);
        wait_edges(20);
        chk("all gated", 4'h0, bank_clk_on);
        @(posedge clk);
        bank_rd <= 4'h1;
        bank_wr <= 4'h2;
        @(posedge clk);
        bank_rd <= 4'h0;
        bank_wr <= 4'h0;
        #1 chk("wake", 4'h3, bank_clk_on);
        chk("stall", 4'h1, bank_read_stall);
        // Sixteen idle cycles keep the clock; the seventeenth stops it.
        wait_edges(16);
        chk("still on", 4'h3, bank_clk_on);
        chk("stall gone", 0, bank_read_stall);
        wait_edges(1);
        chk("regated", 4'h0, bank_clk_on);
        wreg(OFS_RAM_CTRL, 32'hFFFFFFFF);
        bank_wr <= 4'hF;
        @(posedge clk);
        bank_wr <= 4'h0;
        wait_edges(25);
        chk("override", 4'hF, bank_clk_on);
        rreg(OFS_RAM_CTRL, got);
        chk("ram ctrl", 32'h000F0001, got);
        $display("test banks done");
    endtask
    // ==================================================
    // Run control
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #40000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        t_reset();
        t_banks();
        t_irq();
        t_status();
        t_cache();
        t_clocks();
        t_gray();
        report_and_stop();
    end
endmodule
